// [ref_select_defs.svh]
// Constants for the reference select and holdover controller.
// Assumes a 250 MHz control clock; included by its bare name.
`ifndef REF_SELECT_DEFS_SVH
`define REF_SELECT_DEFS_SVH

// Mode select codes, high bit then low bit
`define MODE_NORMAL     2'h0
`define MODE_HOLDOVER   2'h1
`define MODE_FREERUN    2'h2
`define MODE_AUTO       2'h3

// Frequency select codes, high bit then low bit
`define FREQ_RESERVED   2'h0
`define FREQ_8K         2'h1
`define FREQ_1544K      2'h2
`define FREQ_2048K      2'h3

// Timing
`define CLK_PERIOD_NS   4
`define ALIGN_MIN_NS    100
`define ALIGN_CYC       ((`ALIGN_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// [ref_select_pkg.sv]
// Types for the reference select and holdover controller.
// Assumes nothing beyond the defines header.
package ref_select_pkg;

    typedef enum logic [4:0] {
        ST_FREERUN = 5'h01,
        ST_TRACK_A = 5'h02,
        ST_TRACK_B = 5'h04,
        ST_HOLD_A  = 5'h08,
        ST_HOLD_B  = 5'h10
    } state_t;

endpackage : ref_select_pkg

// [reference_select_holdover_fsm.sv]
// Reference selection, holdover state machine and phase error corrector.
// Assumes pins are asynchronous to CLOCK; LINK_CLOCK samples the references.
`timescale 1ns/10ps
`include "ref_select_defs.svh"

module reference_select_holdover_fsm #(
    parameter int CNT_W = 16
) (
    input  wire logic        CLOCK,
    input  wire logic        RESET,
    input  wire logic        LINK_CLOCK,
    input  wire logic        MODE_SEL_HI,
    input  wire logic        MODE_SEL_LO,
    input  wire logic        REF_CHOICE,
    input  wire logic        FREQ_SEL_HI,
    input  wire logic        FREQ_SEL_LO,
    input  wire logic        PRIMARY_LOST,
    input  wire logic        SECONDARY_LOST,
    input  wire logic        GUARD_IN,
    input  wire logic        CORR_RESET_N,
    input  wire logic        REF_A,
    input  wire logic        REF_B,
    output logic             GUARD_OUT,
    output logic             REF_SEL_B,
    output logic             TRACKING,
    output logic             HOLDOVER,
    output logic             FREERUN,
    output logic [4:0]       AUTO_STATE,
    output logic [1:0]       FREQ_CODE,
    output logic             FREQ_INVALID,
    output logic             VIRT_FALL
);

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers, control domain

    logic [8:0] pin_s1_q;
    logic [8:0] pin_s2_q;

    always_ff @(posedge CLOCK) begin
        pin_s1_q <= {MODE_SEL_HI, MODE_SEL_LO, REF_CHOICE, FREQ_SEL_HI, FREQ_SEL_LO,
                     PRIMARY_LOST, SECONDARY_LOST, GUARD_IN, CORR_RESET_N};
        pin_s2_q <= pin_s1_q;
    end

    logic [1:0] mode;
    logic       choice;
    logic [1:0] freq;
    logic       lost_a_raw;
    logic       lost_b_raw;
    logic       guard_in;
    logic       corr_rst_n;
    logic       lost_p;
    logic       lost_s;
    logic       auto_mode;

    assign mode       = pin_s2_q[8:7];
    assign choice     = pin_s2_q[6];
    assign freq       = pin_s2_q[5:4];
    assign lost_a_raw = pin_s2_q[3];
    assign lost_b_raw = pin_s2_q[2];
    assign guard_in   = pin_s2_q[1];
    assign corr_rst_n = pin_s2_q[0];
    assign auto_mode  = (mode == `MODE_AUTO);
    // Roles swap: "primary" loss then watches reference B
    assign lost_p     = choice ? lost_b_raw : lost_a_raw;
    assign lost_s     = choice ? lost_a_raw : lost_b_raw;

    ////////////////////////////////////////////////////////////////////////////
    // Automatic state machine

    ref_select_pkg::state_t state_q;
    ref_select_pkg::state_t state_d;

    always_comb begin
        state_d = state_q;
        if (!auto_mode) begin
            // Manual modes park the machine so automatic entry starts clean
            state_d = ref_select_pkg::ST_FREERUN;
        end else if (!lost_p) begin
            state_d = ref_select_pkg::ST_TRACK_A;
        end else begin
            unique case (state_q)
                ref_select_pkg::ST_FREERUN: begin
                    if (!lost_s) state_d = ref_select_pkg::ST_TRACK_B;
                end
                ref_select_pkg::ST_TRACK_A: begin
                    state_d = ref_select_pkg::ST_HOLD_A;
                end
                ref_select_pkg::ST_TRACK_B: begin
                    if (lost_s) state_d = ref_select_pkg::ST_HOLD_B;
                end
                ref_select_pkg::ST_HOLD_A: begin
                    if (!lost_s && guard_in) state_d = ref_select_pkg::ST_TRACK_B;
                end
                ref_select_pkg::ST_HOLD_B: begin
                    if (!lost_s) state_d = ref_select_pkg::ST_TRACK_B;
                end
                default: state_d = ref_select_pkg::ST_FREERUN;
            endcase
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            state_q <= ref_select_pkg::ST_FREERUN;
        end else begin
            state_q <= state_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Guard timer drive; capacitor discharges whenever no guard runs

    logic guard_q;
    logic guard_d;

    assign guard_d = (state_d == ref_select_pkg::ST_HOLD_A) && !lost_s
                     && (guard_q || state_q == ref_select_pkg::ST_TRACK_A
                         || state_q == ref_select_pkg::ST_HOLD_A);

    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            guard_q <= 1'b0;
        end else begin
            guard_q <= guard_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Operating outputs

    logic sel_b_d;

    always_comb begin
        sel_b_d = choice;
        if (auto_mode) begin
            sel_b_d = (state_q == ref_select_pkg::ST_TRACK_B
                       || state_q == ref_select_pkg::ST_HOLD_B) ^ choice;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            REF_SEL_B  <= 1'b0;
            TRACKING   <= 1'b0;
            HOLDOVER   <= 1'b0;
            FREERUN    <= 1'b1;
            AUTO_STATE <= 5'h01;
        end else begin
            REF_SEL_B  <= sel_b_d;
            AUTO_STATE <= state_q;
            TRACKING   <= auto_mode ? (state_q == ref_select_pkg::ST_TRACK_A
                                       || state_q == ref_select_pkg::ST_TRACK_B)
                                    : (mode == `MODE_NORMAL);
            HOLDOVER   <= auto_mode ? (state_q == ref_select_pkg::ST_HOLD_A
                                       || state_q == ref_select_pkg::ST_HOLD_B)
                                    : (mode == `MODE_HOLDOVER);
            FREERUN    <= auto_mode ? (state_q == ref_select_pkg::ST_FREERUN)
                                    : (mode == `MODE_FREERUN);
        end
    end

    // Oscillator multiplier follows this code; reserved code is flagged
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            FREQ_CODE    <= `FREQ_RESERVED;
            FREQ_INVALID <= 1'b1;
        end else begin
            FREQ_CODE    <= freq;
            FREQ_INVALID <= (freq == `FREQ_RESERVED);
        end
    end

    assign GUARD_OUT = guard_q;

    ////////////////////////////////////////////////////////////////////////////
    // Corrector reset width check; one toggle per qualified low period

    logic [5:0] low_cnt_q;
    logic       align_tog_q;

    always_ff @(posedge CLOCK) begin
        if (RESET || corr_rst_n) begin
            low_cnt_q <= 6'h00;
        end else if (low_cnt_q != 6'(`ALIGN_CYC)) begin
            low_cnt_q <= low_cnt_q + 6'h01;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            align_tog_q <= 1'b0;
        end else if (!corr_rst_n && low_cnt_q == 6'(`ALIGN_CYC - 1)) begin
            align_tog_q <= ~align_tog_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Link domain: corrector

    logic       a_s1_q, a_s2_q, b_s1_q, b_s2_q;
    logic       sel_s1_q, sel_s2_q;
    logic       tog_s1_q, tog_s2_q, tog_s3_q;
    logic       ref_prev_q;
    logic       sel_prev_q;
    logic       sw_pend_q;
    logic       align_pend_q;
    logic       busy_q;
    logic [CNT_W-1:0] since_q;
    logic [CNT_W-1:0] period_q;
    logic [CNT_W-1:0] delay_q;
    logic [CNT_W-1:0] cnt_q;
    logic       cur_ref;
    logic       fall;
    logic       emit;
    logic [CNT_W-1:0] new_delay;

    always_ff @(posedge LINK_CLOCK) begin
        a_s1_q   <= REF_A;
        a_s2_q   <= a_s1_q;
        b_s1_q   <= REF_B;
        b_s2_q   <= b_s1_q;
        sel_s1_q <= REF_SEL_B;
        sel_s2_q <= sel_s1_q;
        tog_s1_q <= align_tog_q;
        tog_s2_q <= tog_s1_q;
        tog_s3_q <= tog_s2_q;
    end

    assign cur_ref = sel_s2_q ? b_s2_q : a_s2_q;
    // Mux swap is not a reference edge; counting it would jump the phase
    assign fall    = ref_prev_q && !cur_ref && (sel_prev_q == sel_s2_q);
    // Offset that lands the new input's edge one link cycle after the old virtual phase
    assign new_delay = align_pend_q ? '0
                     : (sw_pend_q ? ((since_q < period_q) ? period_q - since_q : '0)
                                  : delay_q);
    assign emit    = (fall && new_delay == '0) || (busy_q && cnt_q == CNT_W'(1));

    always_ff @(posedge LINK_CLOCK) begin
        ref_prev_q <= cur_ref;
        sel_prev_q <= sel_s2_q;
        VIRT_FALL  <= emit;
        if (tog_s3_q != tog_s2_q) begin
            align_pend_q <= 1'b1;
        end else if (fall) begin
            align_pend_q <= 1'b0;
        end
        if (sel_prev_q != sel_s2_q) begin
            sw_pend_q <= 1'b1;
        end else if (fall) begin
            sw_pend_q <= 1'b0;
        end
        if (fall) begin
            delay_q <= new_delay;
            cnt_q   <= new_delay;
            busy_q  <= (new_delay != '0);
        end else if (busy_q) begin
            cnt_q  <= cnt_q - CNT_W'(1);
            busy_q <= (cnt_q != CNT_W'(1));
        end
        if (emit) begin
            period_q <= since_q + CNT_W'(1);
            since_q  <= '0;
        end else if (since_q != '1) begin
            since_q <= since_q + CNT_W'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks, control domain

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RESET);

    sequence a_lost_b_good;
        auto_mode && lost_p && !lost_s;
    endsequence

    sequence in_track_a;
        state_q == ref_select_pkg::ST_TRACK_A;
    endsequence

    chk_loss_enters_hold: assert property (in_track_a ##0 a_lost_b_good |=>
        state_q == ref_select_pkg::ST_HOLD_A ##0 GUARD_OUT)
        else $error("Primary loss did not enter hold with guard");

    chk_guard_ends_hold: assert property (state_q == ref_select_pkg::ST_HOLD_A
        ##0 a_lost_b_good ##0 guard_in |=> state_q == ref_select_pkg::ST_TRACK_B)
        else $error("Guard expiry did not switch to B");

    chk_hold_waits_guard: assert property (state_q == ref_select_pkg::ST_HOLD_A
        ##0 a_lost_b_good ##0 !guard_in |=> state_q == ref_select_pkg::ST_HOLD_A)
        else $error("Hold A left before guard time");

    chk_primary_returns: assert property (auto_mode && !lost_p |=>
        state_q == ref_select_pkg::ST_TRACK_A)
        else $error("Primary good did not return to track A");

    chk_both_lost_hold: assert property (auto_mode && lost_p && lost_s
        && state_q == ref_select_pkg::ST_TRACK_B |=> state_q == ref_select_pkg::ST_HOLD_B)
        else $error("Both lost did not hold B");

    chk_freerun_to_b: assert property (state_q == ref_select_pkg::ST_FREERUN
        ##0 a_lost_b_good |=> state_q == ref_select_pkg::ST_TRACK_B)
        else $error("Freerun did not track B");

    chk_holdb_to_b: assert property (state_q == ref_select_pkg::ST_HOLD_B
        ##0 a_lost_b_good |=> state_q == ref_select_pkg::ST_TRACK_B)
        else $error("Hold B did not track B");

    chk_manual_mux: assert property (!auto_mode |=> REF_SEL_B == $past(choice))
        else $error("Manual reference select wrong");

    chk_manual_modes: assert property (mode == `MODE_HOLDOVER |=>
        HOLDOVER && !TRACKING && !FREERUN)
        else $error("Manual holdover not shown");

    chk_swap_roles: assert property (auto_mode && choice
        && state_q == ref_select_pkg::ST_TRACK_A |=> REF_SEL_B)
        else $error("Swapped primary not reference B");

    chk_freq_decode: assert property (1'b1 |=>
        FREQ_CODE == $past(freq) && FREQ_INVALID == ($past(freq) == `FREQ_RESERVED))
        else $error("Frequency code wrong");

    chk_guard_idle: assert property (state_q != ref_select_pkg::ST_HOLD_A
        |-> !GUARD_OUT)
        else $error("Guard driven outside hold A");

    chk_align_width: assert property ($changed(align_tog_q)
        |-> low_cnt_q == 6'(`ALIGN_CYC) && !$past(corr_rst_n))
        else $error("Align toggled before 100 ns low");

endmodule : reference_select_holdover_fsm

// [line_side_model.sv]
// Line side of the controller: loss detectors, reference clocks, guard RC.
// Assumes the bench commands loss; the RC is counted in control clocks.
`timescale 1ns/10ps
module line_side_model #(
    parameter int GUARD_CYC = 40,
    parameter int HALF_A    = 300,
    parameter int HALF_B    = 390
) (
    input  wire logic CLOCK,
    input  wire logic GUARD_OUT,
    input  wire logic a_down,
    input  wire logic b_down,
    output logic      GUARD_IN,
    output logic      PRIMARY_LOST,
    output logic      SECONDARY_LOST,
    output logic      REF_A,
    output logic      REF_B
);
    int charge_q = 0;

    ////////////////////////////////////////////////////////////////////////
    // Capacitor charges while guard output high, dumps at once when low
    always_ff @(posedge CLOCK) begin
        if (!GUARD_OUT)
            charge_q <= 0;
        else if (charge_q < GUARD_CYC)
            charge_q <= charge_q + 1;
    end
    assign GUARD_IN = (charge_q >= GUARD_CYC);

    ////////////////////////////////////////////////////////////////////////
    // A lost reference stops toggling, as a dead line would
    assign PRIMARY_LOST   = a_down;
    assign SECONDARY_LOST = b_down;
    initial begin
        REF_A = 1'b0;
        forever #(HALF_A) REF_A = a_down ? 1'b0 : ~REF_A;
    end
    initial begin
        REF_B = 1'b0;
        forever #(HALF_B) REF_B = b_down ? 1'b0 : ~REF_B;
    end
endmodule : line_side_model

// [tb_top.sv]
// Self-checking bench for the reference select and holdover controller.
// Assumes line_side_model stands at the far side of the loss pins.
`timescale 1ns/10ps
`include "ref_select_defs.svh"
module tb_top;
    logic        clk = 1'b0;
    logic        link_clk = 1'b0;
    logic        rst = 1'b1;
    logic [1:0]  mode = 2'h0;
    logic [1:0]  fsel = 2'h1;
    logic        choice = 1'b0;
    logic        a_dn = 1'b0;
    logic        b_dn = 1'b0;
    logic        corr_n = 1'b1;
    logic        guard_in, guard_out, a_lost, b_lost, ref_a, ref_b;
    logic        sel_b, trk, hold, free, f_bad, virt;
    logic [4:0]  st;
    logic [1:0]  fcode;
    int          mismatches = 0;
    int          checked = 0;
    int          cycles = 0;
    int          n;
    int unsigned seed;
    localparam logic [6:0] TBL [7] = '{
        {2'b11, ref_select_pkg::ST_HOLD_B}, {2'b10, ref_select_pkg::ST_TRACK_B},
        {2'b11, ref_select_pkg::ST_HOLD_B}, {2'b01, ref_select_pkg::ST_TRACK_A},
        {2'b11, ref_select_pkg::ST_HOLD_A}, {2'b11, ref_select_pkg::ST_HOLD_A},
        {2'b01, ref_select_pkg::ST_TRACK_A}};

    // Control clock stands in for the master clock
    initial begin
        forever #2 clk = ~clk;
    end
    // Offset keeps link edges clear of control clock edges
    initial begin
        #7.3;
        forever #15 link_clk = ~link_clk;
    end

    line_side_model u_line_side_model (
        .CLOCK(clk), .GUARD_OUT(guard_out), .a_down(a_dn), .b_down(b_dn),
        .GUARD_IN(guard_in), .PRIMARY_LOST(a_lost), .SECONDARY_LOST(b_lost),
        .REF_A(ref_a), .REF_B(ref_b));

    reference_select_holdover_fsm u_reference_select_holdover_fsm (
        .CLOCK(clk), .RESET(rst), .LINK_CLOCK(link_clk),
        .MODE_SEL_HI(mode[1]), .MODE_SEL_LO(mode[0]), .REF_CHOICE(choice),
        .FREQ_SEL_HI(fsel[1]), .FREQ_SEL_LO(fsel[0]), .PRIMARY_LOST(a_lost),
        .SECONDARY_LOST(b_lost), .GUARD_IN(guard_in), .CORR_RESET_N(corr_n),
        .REF_A(ref_a), .REF_B(ref_b), .GUARD_OUT(guard_out), .REF_SEL_B(sel_b),
        .TRACKING(trk), .HOLDOVER(hold), .FREERUN(free), .AUTO_STATE(st),
        .FREQ_CODE(fcode), .FREQ_INVALID(f_bad), .VIRT_FALL(virt));

    ////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        if (mismatches == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_sim

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : cyc

    // Sync plus state plus output flops take four edges; six leaves margin
    task automatic setp(input logic [1:0] m, input logic c, input logic al, input logic bl);
        mode = m;
        choice = c;
        a_dn = al;
        b_dn = bl;
        cyc(6);
    endtask : setp

    task automatic step(input logic al, input logic bl, input logic [4:0] s);
        setp(`MODE_AUTO, 1'b0, al, bl);
        check(st, s);
        check({trk, hold, free}, {|(s & 5'h06), |(s & 5'h18), s[0]});
        check(guard_out, 1'b0);
    endtask : step

    task automatic wait_sel(input logic v);
        n = 0;
        while (sel_b !== v && n < 100) begin
            cyc(1);
            n++;
        end
    endtask : wait_sel

    // Link cycles from one virtual edge to the next
    task automatic link_gap();
        n = 0;
        do begin
            @(posedge link_clk);
            #1;
            n++;
        end while (virt !== 1'b1 && n < 60);
    endtask : link_gap

    function automatic logic [2:0] exp_flags(input logic [1:0] m);
        case (m)
            `MODE_NORMAL: return 3'h4;
            `MODE_HOLDOVER: return 3'h2;
            default: return 3'h1;
        endcase
    endfunction : exp_flags

    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            end_sim();
        end
    end

    initial begin
        seed = $urandom(34);
        repeat (20) @(posedge clk);
        #1;
        check(st, ref_select_pkg::ST_FREERUN);
        check({trk, hold, free, guard_out, sel_b}, 5'h04);
        check({f_bad, fcode}, 5'h04);
        rst = 1'b0;
        for (int i = 0; i < 8; i++) begin
            fsel = (i < 4) ? 2'(i) : 2'($urandom);
            cyc(6);
            check(fcode, fsel);
            check(f_bad, fsel == `FREQ_RESERVED);
        end
        // Loss pins toggle at random: manual modes must ignore them
        for (int i = 0; i < 12; i++) begin
            setp(2'(i % 3), 1'($urandom), 1'($urandom), 1'($urandom));
            check({trk, hold, free}, exp_flags(mode));
            check(st, ref_select_pkg::ST_FREERUN);
            if (mode == `MODE_NORMAL)
                check(sel_b, choice);
        end
        step(1'b1, 1'b0, ref_select_pkg::ST_TRACK_B);
        check(sel_b, 1'b1);
        step(1'b0, 1'b0, ref_select_pkg::ST_TRACK_A);
        setp(`MODE_AUTO, 1'b0, 1'b1, 1'b0);
        check({st, guard_out}, {ref_select_pkg::ST_HOLD_A, 1'b1});
        cyc(5 + $urandom % 25);
        check(st, ref_select_pkg::ST_HOLD_A);
        wait_sel(1'b1);
        check({st, guard_out}, {ref_select_pkg::ST_TRACK_B, 1'b0});
        for (int i = 0; i < 7; i++)
            step(TBL[i][6], TBL[i][5], TBL[i][4:0]);
        setp(`MODE_AUTO, 1'b1, 1'b0, 1'b0);
        check(sel_b, 1'b1);
        setp(`MODE_AUTO, 1'b1, 1'b0, 1'b1);
        check({hold, guard_out}, 5'h03);
        wait_sel(1'b0);
        check({trk, sel_b}, 5'h02);
        setp(`MODE_NORMAL, 1'b0, 1'b0, 1'b0);
        corr_n = 1'b0;
        cyc(30);
        corr_n = 1'b1;
        // Align flag needs up to three link cycles to cross before an edge uses it
        cyc(30);
        @(negedge ref_a);
        n = 0;
        while (virt !== 1'b1 && n < 8) begin
            @(posedge link_clk);
            #1;
            n++;
        end
        check(n < 5, 1'b1);
        link_gap();
        check(8'(n), 8'h14);
        // Switch just after a virtual edge, while reference A is still low
        @(posedge clk);
        #1;
        choice = 1'b1;
        link_gap();
        check(n >= 20 && n < 60, 1'b1);
        end_sim();
    end
endmodule : tb_top
